// >>> rtl/uart_enhanced_feature_control.sv
`timescale 1ns/10ps

module uart_enhanced_feature_control #(
  parameter int unsigned FIFO_DEPTH = 128,
  parameter int unsigned COUNT_W = 8
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [COUNT_W-1:0] rx_fifo_count_i,
  input wire logic [COUNT_W-1:0] tx_fifo_count_i,
  input wire logic tx_fifo_write_i,
  input wire logic tx_hold_empty_i,
  input wire logic tx_shift_empty_i,
  input wire logic bit_tick_i,
  input wire logic half_duplex_pin_n_i,
  input wire logic rts_gp_n_i,
  input wire logic rx_serial_i,
  output logic rx_irda_o,
  output logic rts_n_o,
  output logic tx_irq_o,
  output logic [7:0] rx_trigger_o,
  output logic [7:0] tx_trigger_o,
  output logic [1:0] trig_table_o,
  output logic [1:0] rts_hyst_o,
  output logic [1:0] ext_hyst_o,
  input wire logic [7:0] rx_char_i,
  input wire logic rx_char_valid_i,
  output logic xon_seen_o,
  output logic xoff_seen_o,
  input wire logic send_xon_i,
  input wire logic send_xoff_i,
  output logic [7:0] flow_char_o,
  output logic flow_valid_o,
  input wire logic flow_ready_i
);

  // Occupancy clipped to the FIFO depth, so a glitching counter never
  // reports more characters than the FIFO can hold.
  function automatic logic [7:0] clamp_count(input logic [COUNT_W-1:0] c);
    logic [7:0] res;
    res = 8'(c);
    if (32'(c) > FIFO_DEPTH) begin
      res = 8'(FIFO_DEPTH);
    end
    return res;
  endfunction

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  // Software visible registers.
  logic [7:0] line_control_reg_r;
  logic [7:0] scratch_r;
  logic [7:0] feature_control_r;
  logic [7:0] enhanced_feature_select_r;
  logic [7:0] enhanced_mode_select_r;
  logic [7:0] rx_trig_r;
  logic [7:0] tx_trig_r;
  logic [7:0] xon1_r;
  logic [7:0] xon2_r;
  logic [7:0] xoff1_r;
  logic [7:0] xoff2_r;
  // Alternate counter mode: next read shows the transmit count.
  logic alt_tx_r;
  // Read data is captured in the setup cycle.
  logic [7:0] rdata_r;

  // Bus decode.
  wire setup_w = psel_i && !penable_i;
  wire access_w = psel_i && penable_i;
  wire enh_open_w = (line_control_reg_r == uart_efc_pkg::LINE_CTRL_ENH_KEY);
  wire hit_line_w = (paddr_i == uart_efc_pkg::ADDR_LINE_CTRL);
  wire hit_scr_w = (paddr_i == uart_efc_pkg::ADDR_SCRATCH);
  wire hit_feat_w = (paddr_i == uart_efc_pkg::ADDR_FEATURE);
  wire hit_efs_w = (paddr_i == uart_efc_pkg::ADDR_ENH_SELECT);
  wire hit_trig_w = (paddr_i == uart_efc_pkg::ADDR_TRIG_LEVEL);
  wire hit_xon1_w = (paddr_i == uart_efc_pkg::ADDR_XON1);
  wire hit_xon2_w = (paddr_i == uart_efc_pkg::ADDR_XON2);
  wire hit_xoff1_w = (paddr_i == uart_efc_pkg::ADDR_XOFF1);
  wire hit_xoff2_w = (paddr_i == uart_efc_pkg::ADDR_XOFF2);
  wire hit_any_w = hit_line_w || hit_scr_w || hit_feat_w || hit_efs_w ||
                   hit_trig_w || hit_xon1_w || hit_xon2_w || hit_xoff1_w ||
                   hit_xoff2_w;
  // The trigger and count word answers only behind the key value.
  wire bad_w = !hit_any_w || (hit_trig_w && !enh_open_w);
  wire wr_w = access_w && pwrite_i && !bad_w;
  wire rd_done_w = access_w && !pwrite_i && !bad_w;
  wire [7:0] wd_w = pwdata_i[7:0];

  // Field views.
  wire swap_w = feature_control_r[uart_efc_pkg::FEAT_SWAP];
  wire tx_sel_w = feature_control_r[uart_efc_pkg::FEAT_TX_SEL];
  wire irda_inv_w = feature_control_r[uart_efc_pkg::FEAT_IRDA_INV];
  wire [1:0] table_w = feature_control_r[uart_efc_pkg::FEAT_TABLE_LO +: 2];
  wire [1:0] rx_flow_w =
    enhanced_feature_select_r[uart_efc_pkg::EFS_RX_LO +: 2];
  wire [1:0] tx_flow_w =
    enhanced_feature_select_r[uart_efc_pkg::EFS_TX_LO +: 2];
  wire [1:0] count_mode_w =
    enhanced_mode_select_r[uart_efc_pkg::EMS_COUNT_LO +: 2];
  wire [7:0] rx_count_w = clamp_count(rx_fifo_count_i);
  wire [7:0] tx_count_w = clamp_count(tx_fifo_count_i);

  wire [7:0] data_count_w = tx_sel_w ? tx_count_w : rx_count_w;
  wire level_tx_w =
    (count_mode_w == uart_efc_pkg::COUNT_TX) ||
    ((count_mode_w == uart_efc_pkg::COUNT_ALTERNATE) && alt_tx_r);
  wire [7:0] level_w = level_tx_w ? tx_count_w : rx_count_w;
  wire [7:0] scr_rd_w = swap_w ? level_w : scratch_r;

  // Read multiplexer; the trigger word reads back the data count.
  wire [7:0] rd8_w =
    hit_line_w ? line_control_reg_r :
    hit_scr_w ? scr_rd_w :
    hit_feat_w ? feature_control_r :
    hit_efs_w ? enhanced_feature_select_r :
    (hit_trig_w && enh_open_w) ? data_count_w :
    hit_xon1_w ? xon1_r :
    hit_xon2_w ? xon2_r :
    hit_xoff1_w ? xoff1_r :
    hit_xoff2_w ? xoff2_r : 8'h00;

  // Zero wait states: every access completes in its first access cycle.
  assign pready_o = 1'b1;
  assign pslverr_o = access_w && bad_w;
  assign prdata_o = {24'h00_0000, rdata_r};

  // Capture read data in the setup cycle; an error answer reads zero.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rdata_r <= 8'h00;
    end else if (setup_w) begin
      rdata_r <= (pwrite_i || bad_w) ? 8'h00 : rd8_w;
    end
  end

  fc_gate_a: assert property (
    access_w && !pwrite_i && hit_trig_w && !enh_open_w |->
      pslverr_o && prdata_o == 32'h0000_0000)
    else $error("count word answered without the key value");

  fc_range_a: assert property (
    access_w && !pwrite_i && hit_trig_w && enh_open_w |->
      32'(prdata_o) <= FIFO_DEPTH)
    else $error("count read above the FIFO depth");

  // Plain control registers written on a completed access.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      line_control_reg_r <= uart_efc_pkg::RST_LINE_CTRL;
      feature_control_r <= uart_efc_pkg::RST_FEATURE;
      enhanced_feature_select_r <= uart_efc_pkg::RST_ENH_SELECT;
      xon1_r <= uart_efc_pkg::RST_FLOW_CHAR;
      xon2_r <= uart_efc_pkg::RST_FLOW_CHAR;
      xoff1_r <= uart_efc_pkg::RST_FLOW_CHAR;
      xoff2_r <= uart_efc_pkg::RST_FLOW_CHAR;
    end else if (wr_w) begin
      if (hit_line_w) line_control_reg_r <= wd_w;
      if (hit_feat_w) feature_control_r <= wd_w;
      if (hit_efs_w) enhanced_feature_select_r <= wd_w;
      if (hit_xon1_w) xon1_r <= wd_w;
      if (hit_xon2_w) xon2_r <= wd_w;
      if (hit_xoff1_w) xoff1_r <= wd_w;
      if (hit_xoff2_w) xoff2_r <= wd_w;
    end
  end

  efs_reset_a: assert property (
    disable iff (1'b0) reset_i |=> enhanced_feature_select_r == 8'h00)
    else $error("flow control select not clear after reset");

  hyst_reset_a: assert property (
    disable iff (1'b0) reset_i |=> rts_hyst_o == 2'b00)
    else $error("hysteresis field not zero after reset");

  // Trigger levels: the direction bit picks the target of each write.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rx_trig_r <= uart_efc_pkg::RST_TRIG_LEVEL;
      tx_trig_r <= uart_efc_pkg::RST_TRIG_LEVEL;
    end else if (wr_w && hit_trig_w) begin
      if (tx_sel_w) begin
        tx_trig_r <= wd_w;
      end else begin
        rx_trig_r <= wd_w;
      end
    end
  end

  trg_dir_a: assert property (
    wr_w && hit_trig_w && !tx_sel_w |=>
      rx_trig_r == $past(pwdata_i[7:0]) && $stable(tx_trig_r))
    else $error("trigger write reached the wrong FIFO");

  // Scratch location: storage, or mode select when swapped.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      scratch_r <= uart_efc_pkg::RST_SCRATCH;
      enhanced_mode_select_r <= uart_efc_pkg::RST_MODE_SELECT;
    end else if (wr_w && hit_scr_w) begin
      if (swap_w) begin
        enhanced_mode_select_r <= wd_w & uart_efc_pkg::EMS_KEEP_MASK;
      end else begin
        scratch_r <= wd_w;
      end
    end
  end

  // Alternate mode starts with the receive count after each mode write,
  // then flips on every completed level read.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      alt_tx_r <= 1'b0;
    end else if (wr_w && hit_scr_w && swap_w) begin
      alt_tx_r <= 1'b0;
    end else if (rd_done_w && hit_scr_w && swap_w &&
                 count_mode_w == uart_efc_pkg::COUNT_ALTERNATE) begin
      alt_tx_r <= !alt_tx_r;
    end
  end

  spr_rw_a: assert property (
    wr_w && hit_scr_w && !swap_w |=> scratch_r == $past(pwdata_i[7:0]))
    else $error("scratch storage lost a write");

  swap_rd_a: assert property (
    setup_w && !pwrite_i && hit_scr_w && swap_w &&
    count_mode_w == uart_efc_pkg::COUNT_RX |=>
      prdata_o[7:0] == clamp_count($past(rx_fifo_count_i)))
    else $error("swapped scratch read did not show the receive count");

  // programmed level only for table D.
  wire table_d_w = (table_w == uart_efc_pkg::TABLE_D);
  assign rx_trigger_o = table_d_w ? rx_trig_r : 8'h00;
  assign tx_trigger_o = table_d_w ? tx_trig_r : 8'h00;
  assign trig_table_o = table_w;
  assign rts_hyst_o = feature_control_r[uart_efc_pkg::FEAT_HYST_LO +: 2];
  assign ext_hyst_o = enhanced_mode_select_r[uart_efc_pkg::EMS_HYST_LO +: 2];

  trig_tbl_a: assert property (
    !table_d_w |-> rx_trigger_o == 8'h00 && tx_trigger_o == 8'h00)
    else $error("programmed level used outside table D");

  tbl_sel_a: assert property (
    wr_w && hit_feat_w |=> trig_table_o == $past(pwdata_i[5:4]))
    else $error("trigger table does not follow its field");

  // polarity of the receive input, registered so the decoder sees
  // a clean level that follows the input, inverted while the invert bit is set.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rx_irda_o <= 1'b0;
    end else begin
      rx_irda_o <= irda_inv_w ? !rx_serial_i : rx_serial_i;
    end
  end

  irda_pol_a: assert property (
    ##1 rx_irda_o == ($past(irda_inv_w) ^ $past(rx_serial_i)))
    else $error("receive polarity does not follow its bit");

  wire auto_dir_w = !half_duplex_pin_n_i ||
                    feature_control_r[uart_efc_pkg::FEAT_AUTO_DIR];
  // Direction level (high is receive) and the one-bit wait after drain.
  logic dir_r;
  logic dir_wait_r;
  logic dir_nxt;
  logic dir_wait_nxt;
  wire drained_w = tx_shift_empty_i && tx_hold_empty_i;

  // Direction next state; a FIFO write beats a pending bit tick.
  always_comb begin
    dir_nxt = dir_r;
    dir_wait_nxt = dir_wait_r;
    if (tx_fifo_write_i) begin
      dir_nxt = 1'b0;
      dir_wait_nxt = 1'b0;
    end else if (dir_wait_r && !drained_w) begin
      dir_wait_nxt = 1'b0;
    end else if (dir_wait_r && bit_tick_i) begin
      dir_nxt = 1'b1;
      dir_wait_nxt = 1'b0;
    end else if (!dir_r && drained_w && !dir_wait_r) begin
      dir_wait_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      dir_r <= 1'b1;
      dir_wait_r <= 1'b0;
    end else begin
      dir_r <= dir_nxt;
      dir_wait_r <= dir_wait_nxt;
    end
  end

  // output choice by pin and bit.
  assign rts_n_o = auto_dir_w ? dir_r : rts_gp_n_i;
  assign tx_irq_o = auto_dir_w ? drained_w : tx_hold_empty_i;

  sequence drain_s;
    !dir_r && !dir_wait_r && drained_w && !tx_fifo_write_i;
  endsequence

  sequence one_bit_s;
    dir_wait_r && drained_w && bit_tick_i && !tx_fifo_write_i;
  endsequence

  dir_rise_a: assert property (
    drain_s ##1 one_bit_s |=> dir_r)
    else $error("direction did not rise one bit after drain");

  dir_fall_a: assert property (
    tx_fifo_write_i |=> !dir_r ##0 !dir_wait_r)
    else $error("direction not low after a FIFO write");

  pin_dir_a: assert property (
    !half_duplex_pin_n_i |-> rts_n_o == dir_r)
    else $error("tied-low pin did not force direction control");

  irq_std_a: assert property (
    !auto_dir_w |-> tx_irq_o == tx_hold_empty_i)
    else $error("standard transmit interrupt wrong");

  irq_auto_a: assert property (
    auto_dir_w && !tx_shift_empty_i |-> !tx_irq_o)
    else $error("interrupt raised while shifter busy");

  wire rx_both_w = (rx_flow_w == uart_efc_pkg::FLOW_BOTH);
  wire tx_single_w = (tx_flow_w == uart_efc_pkg::FLOW_FIRST) ||
                     (tx_flow_w == uart_efc_pkg::FLOW_SECOND);
  wire seq_mode_w = rx_both_w && !tx_single_w;
  wire take1_w = (rx_flow_w == uart_efc_pkg::FLOW_FIRST) ||
                 (rx_both_w && tx_single_w);
  wire take2_w = (rx_flow_w == uart_efc_pkg::FLOW_SECOND) ||
                 (rx_both_w && tx_single_w);
  wire on_single_w = (take1_w && rx_char_i == xon1_r) ||
                     (take2_w && rx_char_i == xon2_r);
  wire off_single_w = (take1_w && rx_char_i == xoff1_r) ||
                      (take2_w && rx_char_i == xoff2_r);

  uart_efc_pkg::match_state_t match_r;
  uart_efc_pkg::match_state_t match_nxt;
  logic on_nxt;
  logic off_nxt;

  always_comb begin
    match_nxt = match_r;
    on_nxt = 1'b0;
    off_nxt = 1'b0;
    if (rx_char_valid_i && seq_mode_w) begin
      // A character that breaks a sequence may itself start a new one.
      match_nxt = (rx_char_i == xon1_r) ? uart_efc_pkg::MATCH_ON_FIRST :
                  (rx_char_i == xoff1_r) ? uart_efc_pkg::MATCH_OFF_FIRST :
                  uart_efc_pkg::MATCH_IDLE;
      case (match_r)
        uart_efc_pkg::MATCH_ON_FIRST: begin
          if (rx_char_i == xon2_r) begin
            on_nxt = 1'b1;
            match_nxt = uart_efc_pkg::MATCH_IDLE;
          end
        end
        uart_efc_pkg::MATCH_OFF_FIRST: begin
          if (rx_char_i == xoff2_r) begin
            off_nxt = 1'b1;
            match_nxt = uart_efc_pkg::MATCH_IDLE;
          end
        end
        default: begin
        end
      endcase
    end else if (rx_char_valid_i) begin
      on_nxt = on_single_w;
      off_nxt = off_single_w && !on_single_w;
      match_nxt = uart_efc_pkg::MATCH_IDLE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      match_r <= uart_efc_pkg::MATCH_IDLE;
      xon_seen_o <= 1'b0;
      xoff_seen_o <= 1'b0;
    end else begin
      match_r <= match_nxt;
      xon_seen_o <= on_nxt;
      xoff_seen_o <= off_nxt;
    end
  end

  seq_on_a: assert property (
    seq_mode_w && match_r == uart_efc_pkg::MATCH_ON_FIRST &&
    rx_char_valid_i && rx_char_i == xon2_r |=> xon_seen_o)
    else $error("on sequence not recognised");

  seq_lone_a: assert property (
    seq_mode_w && match_r == uart_efc_pkg::MATCH_IDLE |=> !xon_seen_o)
    else $error("on recognised without its first character");

  either_a: assert property (
    rx_both_w && tx_single_w && rx_char_valid_i && rx_char_i == xon2_r
      |=> xon_seen_o)
    else $error("second on character not accepted");

  rx_first_a: assert property (
    rx_flow_w == uart_efc_pkg::FLOW_FIRST && rx_char_valid_i &&
    rx_char_i == xoff1_r && rx_char_i != xon1_r |=> xoff_seen_o)
    else $error("first off character not recognised");

  uart_efc_pkg::send_state_t send_r;
  logic send_off_r;
  wire send_req_w = (send_xon_i || send_xoff_i) &&
                    (tx_flow_w != uart_efc_pkg::FLOW_NONE);
  wire req_off_w = send_xoff_i;

  // Off takes priority when both requests arrive together.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      send_r <= uart_efc_pkg::SEND_IDLE;
      send_off_r <= 1'b0;
      flow_char_o <= 8'h00;
    end else begin
      case (send_r)
        uart_efc_pkg::SEND_IDLE: begin
          if (send_req_w) begin
            send_off_r <= req_off_w;
            send_r <= uart_efc_pkg::SEND_FIRST;
            if (tx_flow_w == uart_efc_pkg::FLOW_SECOND) begin
              flow_char_o <= req_off_w ? xoff2_r : xon2_r;
            end else begin
              flow_char_o <= req_off_w ? xoff1_r : xon1_r;
            end
          end
        end
        uart_efc_pkg::SEND_FIRST: begin
          if (flow_ready_i && tx_flow_w == uart_efc_pkg::FLOW_BOTH) begin
            send_r <= uart_efc_pkg::SEND_SECOND;
            flow_char_o <= send_off_r ? xoff2_r : xon2_r;
          end else if (flow_ready_i) begin
            send_r <= uart_efc_pkg::SEND_IDLE;
          end
        end
        uart_efc_pkg::SEND_SECOND: begin
          if (flow_ready_i) begin
            send_r <= uart_efc_pkg::SEND_IDLE;
          end
        end
        default: begin
          send_r <= uart_efc_pkg::SEND_IDLE;
        end
      endcase
    end
  end

  assign flow_valid_o = (send_r != uart_efc_pkg::SEND_IDLE);

  // The sink may stall for any number of cycles, so the pair is checked
  // from the edge at which the first on character is taken.
  sequence xon_pair_s;
    send_r == uart_efc_pkg::SEND_FIRST && !send_off_r &&
    tx_flow_w == uart_efc_pkg::FLOW_BOTH && flow_ready_i;
  endsequence

  tx_pair_a: assert property (
    xon_pair_s |=> flow_valid_o && flow_char_o == xon2_r)
    else $error("dual on pair not sent in order");

endmodule

// >>> rtl/uart_efc_pkg.sv
package uart_efc_pkg;

  // Byte addresses of the register words on the APB bus.
  localparam logic [7:0] ADDR_LINE_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SCRATCH = 8'h04;
  localparam logic [7:0] ADDR_FEATURE = 8'h08;
  localparam logic [7:0] ADDR_ENH_SELECT = 8'h0C;
  localparam logic [7:0] ADDR_TRIG_LEVEL = 8'h10;
  localparam logic [7:0] ADDR_XON1 = 8'h14;
  localparam logic [7:0] ADDR_XON2 = 8'h18;
  localparam logic [7:0] ADDR_XOFF1 = 8'h1C;
  localparam logic [7:0] ADDR_XOFF2 = 8'h20;

  // Values after reset.
  localparam logic [7:0] RST_LINE_CTRL = 8'h00;
  localparam logic [7:0] RST_SCRATCH = 8'hFF;
  localparam logic [7:0] RST_FEATURE = 8'h00;
  localparam logic [7:0] RST_ENH_SELECT = 8'h00;
  localparam logic [7:0] RST_MODE_SELECT = 8'h00;
  localparam logic [7:0] RST_FLOW_CHAR = 8'h00;
  localparam logic [7:0] RST_TRIG_LEVEL = 8'h00;

  // Line control value that opens the enhanced register set.
  localparam logic [7:0] LINE_CTRL_ENH_KEY = 8'hBF;

  // Field positions in the feature control register.
  localparam int unsigned FEAT_HYST_LO = 0;
  localparam int unsigned FEAT_IRDA_INV = 2;
  localparam int unsigned FEAT_AUTO_DIR = 3;
  localparam int unsigned FEAT_TABLE_LO = 4;
  localparam int unsigned FEAT_SWAP = 6;
  localparam int unsigned FEAT_TX_SEL = 7;

  // Field positions in the enhanced feature select register.
  localparam int unsigned EFS_RX_LO = 0;
  localparam int unsigned EFS_TX_LO = 2;

  // Field positions in the enhanced mode select register.
  localparam int unsigned EMS_COUNT_LO = 0;
  localparam int unsigned EMS_HYST_LO = 4;

  // Only the defined mode select bits are kept; the rest are stored as zero.
  localparam logic [7:0] EMS_KEEP_MASK = 8'h33;

  // Trigger table selection.
  typedef enum logic [1:0] {
    TABLE_A = 2'b00,
    TABLE_B = 2'b01,
    TABLE_C = 2'b10,
    TABLE_D = 2'b11
  } trig_table_t;

  // Software flow control selection for one direction.
  typedef enum logic [1:0] {
    FLOW_NONE = 2'b00,
    FLOW_SECOND = 2'b01,
    FLOW_FIRST = 2'b10,
    FLOW_BOTH = 2'b11
  } flow_sel_t;

  // Level counter modes seen through the scratch location.
  typedef enum logic [1:0] {
    COUNT_RX = 2'b00,
    COUNT_TX = 2'b01,
    COUNT_RX_ALT = 2'b10,
    COUNT_ALTERNATE = 2'b11
  } count_mode_t;

  // Receive sequence matcher states.
  typedef enum logic [1:0] {
    MATCH_IDLE = 2'b00,
    MATCH_ON_FIRST = 2'b01,
    MATCH_OFF_FIRST = 2'b10
  } match_state_t;

  // Transmit flow character sender states.
  typedef enum logic [1:0] {
    SEND_IDLE = 2'b00,
    SEND_FIRST = 2'b01,
    SEND_SECOND = 2'b11
  } send_state_t;

endpackage

// >>> dv/far_side_model.sv
`timescale 1ns/10ps
// Far side: a slow bit clock and a flow character sink that stalls.
module far_side_model (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic flow_valid_i,
  output logic bit_tick_o,
  output logic flow_ready_o
);
  logic [2:0] div_r; // Bit time divider, one tick in eight cycles.
  // The sink accepts at most every other cycle, so the sender must hold.
  always_ff @(posedge clk_i) begin
    div_r <= reset_i ? 3'h0 : div_r + 3'h1;
    flow_ready_o <= !reset_i && flow_valid_i && !flow_ready_o;
  end
  assign bit_tick_o = (div_r == 3'h7);
endmodule

// >>> dv/testbench.sv
`timescale 1ns/10ps
module testbench;
  logic clk_i = 0, reset_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic tx_fifo_write_i = 0, tx_hold_empty_i = 1, tx_shift_empty_i = 0;
  logic half_duplex_pin_n_i = 1, rts_gp_n_i = 1, rx_serial_i = 0;
  logic rx_char_valid_i = 0, send_xon_i = 0, send_xoff_i = 0, er;
  logic bit_tick_i, flow_ready_i, rx_irda_o, rts_n_o, tx_irq_o, pready_o;
  logic pslverr_o, xon_seen_o, xoff_seen_o, flow_valid_o;
  logic [7:0] paddr_i = 0, rx_fifo_count_i = 8'h05, tx_fifo_count_i = 8'h09;
  logic [7:0] rx_char_i = 0, rx_trigger_o, tx_trigger_o, flow_char_o, rd;
  logic [1:0] trig_table_o, rts_hyst_o, ext_hyst_o;
  logic [31:0] pwdata_i = 0, prdata_o;
  int error_cnt = 0, tests_run = 0, cyc = 0, n;
  uart_enhanced_feature_control uut (.*);
  far_side_model far (.clk_i(clk_i), .reset_i(reset_i),
    .flow_valid_i(flow_valid_o), .bit_tick_o(bit_tick_i),
    .flow_ready_o(flow_ready_i));
  initial forever #2 clk_i = ~clk_i;
  // One APB transfer; data and error are taken at the pready edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    psel_i <= 1; penable_i <= 0; pwrite_i <= w; paddr_i <= a;
    pwdata_i <= {24'h0000_00, d};
    @(posedge clk_i);
    penable_i <= 1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    rd = prdata_o[7:0];
    er = pslverr_o;
    psel_i <= 0;
    penable_i <= 0;
    // Return just after the edge, so that a write is visible to checks.
    #1;
  endtask
  // One received character; the seen pulses stand when it returns.
  task automatic rxc(input logic [7:0] c);
    @(posedge clk_i);
    rx_char_i <= c;
    rx_char_valid_i <= 1;
    @(posedge clk_i);
    rx_char_valid_i <= 0;
    #1;
  endtask
  // An on request, then a wait until the sender offers a character.
  task automatic snd;
    @(posedge clk_i);
    send_xon_i <= 1;
    @(posedge clk_i);
    send_xon_i <= 0;
    for (n = 0; n < 9 && flow_valid_o !== 1'b1; n++) @(posedge clk_i) #1;
  endtask
  task automatic chk(input string s, input logic [7:0] v, input logic [7:0] e);
    tests_run++;
    if (v !== e) begin
      error_cnt++;
      $display("BAD %s exp %h seen %h", s, e, v);
    end
  endtask
  task automatic end_of_test;
    if (error_cnt == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // A hang is cut short well beyond the fewer than two hundred cycles needed.
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      end_of_test;
    end
  end
  initial begin
    repeat (16) @(posedge clk_i);
    reset_i <= 0;
    apb(0, uart_efc_pkg::ADDR_SCRATCH, 0); chk("spr", rd, 8'hFF);
    apb(0, uart_efc_pkg::ADDR_ENH_SELECT, 0); chk("efs", rd, 8'h00);
    apb(1, uart_efc_pkg::ADDR_SCRATCH, 8'h5A);
    apb(0, uart_efc_pkg::ADDR_SCRATCH, 0); chk("spr", rd, 8'h5A);
    apb(1, uart_efc_pkg::ADDR_TRIG_LEVEL, 8'h21); chk("lock", er, 1);
    apb(1, 8'h24, 8'h00); chk("unmapped", er, 1);
    apb(1, uart_efc_pkg::ADDR_LINE_CTRL, 8'hBF);
    apb(1, uart_efc_pkg::ADDR_FEATURE, 8'h36);
    apb(1, uart_efc_pkg::ADDR_TRIG_LEVEL, 8'h21);
    chk("rxtrg", rx_trigger_o, 8'h21);
    chk("table", trig_table_o, 3);
    chk("hyst", rts_hyst_o, 2);
    chk("irda", rx_irda_o, 1);
    apb(0, uart_efc_pkg::ADDR_TRIG_LEVEL, 0); chk("rxcnt", rd, 8'h05);
    apb(1, uart_efc_pkg::ADDR_FEATURE, 8'hB6);
    apb(1, uart_efc_pkg::ADDR_TRIG_LEVEL, 8'h44);
    chk("txtrg", tx_trigger_o, 8'h44);
    apb(0, uart_efc_pkg::ADDR_TRIG_LEVEL, 0); chk("txcnt", rd, 8'h09);
    apb(1, uart_efc_pkg::ADDR_FEATURE, 8'h84);
    chk("rxtrg", rx_trigger_o, 0);
    apb(1, uart_efc_pkg::ADDR_FEATURE, 8'h40);
    apb(0, uart_efc_pkg::ADDR_SCRATCH, 0); chk("level", rd, 8'h05);
    // Alternate counter mode with the top hysteresis code.
    apb(1, uart_efc_pkg::ADDR_SCRATCH, 8'h33);
    chk("ehyst", ext_hyst_o, 3);
    apb(0, uart_efc_pkg::ADDR_SCRATCH, 0); chk("alt_rx", rd, 8'h05);
    apb(0, uart_efc_pkg::ADDR_SCRATCH, 0); chk("alt_tx", rd, 8'h09);
    apb(1, uart_efc_pkg::ADDR_FEATURE, 8'h00);
    chk("irq", tx_irq_o, 1);
    // Pin tied low turns on auto direction with the feature bit clear.
    @(posedge clk_i) half_duplex_pin_n_i <= 0;
    tx_fifo_write_i <= 1;
    @(posedge clk_i) tx_fifo_write_i <= 0;
    @(posedge clk_i) #1;
    chk("dir", rts_n_o, 0);
    chk("irq", tx_irq_o, 0);
    @(posedge clk_i) tx_shift_empty_i <= 1;
    for (n = 0; n < 20 && rts_n_o !== 1'b1; n++) @(posedge clk_i) #1;
    chk("dir", rts_n_o, 1);
    chk("late", n > 1 && n < 12, 1);
    apb(1, uart_efc_pkg::ADDR_ENH_SELECT, 8'h00);
    apb(1, uart_efc_pkg::ADDR_ENH_SELECT, 8'h0A);
    apb(1, uart_efc_pkg::ADDR_XON1, 8'h11);
    apb(1, uart_efc_pkg::ADDR_XON2, 8'h22);
    rxc(8'h11); chk("xon", xon_seen_o, 1);
    rxc(8'h00); chk("xoff", xoff_seen_o, 1);
    snd; chk("txchar", flow_char_o, 8'h11);
    // Mixed mode: the second on character alone is accepted.
    apb(1, uart_efc_pkg::ADDR_ENH_SELECT, 8'h00);
    apb(1, uart_efc_pkg::ADDR_ENH_SELECT, 8'h0B);
    rxc(8'h22); chk("either", xon_seen_o, 1);
    // Dual mode: only the ordered pair counts, and a pair is sent.
    apb(1, uart_efc_pkg::ADDR_ENH_SELECT, 8'h00);
    apb(1, uart_efc_pkg::ADDR_ENH_SELECT, 8'h0F);
    rxc(8'h22); chk("lone", xon_seen_o, 0);
    rxc(8'h11); chk("half", xon_seen_o, 0);
    rxc(8'h22); chk("pair", xon_seen_o, 1);
    snd; chk("dual1", flow_char_o, 8'h11);
    for (n = 0; n < 9 && flow_char_o !== 8'h22; n++) @(posedge clk_i) #1;
    chk("dual2", flow_char_o, 8'h22);
    chk("dualv", flow_valid_o, 1);
    end_of_test;
  end
endmodule
